// [core/tfw_pkg.sv]
// Shared constants and state encoding for the tape write sequencer
package tfw_pkg;
    // Field widths
    localparam int FC_W   = 16;
    localparam int CHAR_W = 8;
    localparam int CNT_W  = 8;
    localparam int DLY_W  = 12;
    // Function codes (octal 61 and 27)
    localparam logic [5:0] FN_WRITE_FWD = 6'h31;
    localparam logic [5:0] FN_WRITE_TM  = 6'h17;
    // Density code that selects phase encoding
    localparam logic [2:0] DEN_PE = 3'h4;
    // Character patterns
    localparam logic [7:0] CHAR_ZERO    = 8'h00;
    localparam logic [7:0] CHAR_ONES    = 8'hFF;
    localparam logic [7:0] TM_NRZI_CHAR = 8'h13;
    localparam logic [7:0] TM_PE_LOW    = 8'h58;
    // Counts of characters and pulses
    localparam logic [7:0] PRE_ZEROS    = 8'h28;
    localparam logic [7:0] TM_PE_PULSES = 8'h50;
    localparam logic [7:0] TM_GAP_CHARS = 8'h07;
    localparam logic [7:0] CNT_ONE      = 8'h01;
    localparam logic [15:0] FC_ONE      = 16'h0001;
    localparam logic [15:0] FC_LAST     = 16'hFFFF;
    localparam logic [8:0] CRC_POLY     = 9'h0F3;
    // Sequencer states, one-hot
    typedef enum logic [13:0] {
        S_IDLE  = 14'h0001,
        S_RUNW  = 14'h0002,
        S_ACCEL = 14'h0004,
        S_IDB   = 14'h0008,
        S_PRE   = 14'h0010,
        S_DATA  = 14'h0020,
        S_POST  = 14'h0040,
        S_CRC   = 14'h0080,
        S_LRC   = 14'h0100,
        S_TMPE  = 14'h0200,
        S_TMNR  = 14'h0400,
        S_TMGAP = 14'h0800,
        S_READ  = 14'h1000,
        S_STOPD = 14'h2000
    } tfw_state_t;
endpackage

// [core/tfw_parts.sv]
// Rate divider and motion delay counter used by the write sequencer
`timescale 1ns/100ps
module tfw_rate_div
    import tfw_pkg::*;
#(
    parameter logic [7:0] RATE_DIV = 8'h04
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // Reference clock edge in, rate tick out
    input  wire logic ref_edge,
    output logic      rate_tick
);
    logic [7:0] div_ff;
    logic       tick_ff;
    wire        wrap = (div_ff == RATE_DIV - 8'h01);

    // Divide reference edges down to the delay rate
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            div_ff  <= 8'h00;
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= ref_edge & wrap;
            if (ref_edge) begin
                div_ff <= wrap ? 8'h00 : div_ff + 8'h01;
            end
        end
    end
    assign rate_tick = tick_ff;
endmodule

module tfw_motion_delay
    import tfw_pkg::*;
#(
    parameter logic [11:0] MOTION_DELAY = 12'h010
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // Start, rate tick and completion pulse
    input  wire logic start,
    input  wire logic rate_tick,
    output logic      done
);
    logic [DLY_W-1:0] cnt_ff;
    logic             busy_ff;
    logic             done_ff;
    wire              last = (cnt_ff == MOTION_DELAY - 12'h001);

    // Count rate ticks from start to the delay length
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_ff  <= 12'h000;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            done_ff <= busy_ff & rate_tick & last;
            if (start) begin
                cnt_ff  <= 12'h000;
                busy_ff <= 1'b1;
            end else if (busy_ff && rate_tick) begin
                cnt_ff  <= cnt_ff + 12'h001;
                busy_ff <= !last;
            end
        end
    end
    assign done = done_ff;
endmodule

// [core/tfw_write_seq.sv]
// Write sequencer of the tape formatter: data write and tape mark
// Summary of operation
// - Tape control write drives select and density
// - Write forward asserts forward and write lines
// - Bus occupied only after error-free decode
// - Run starts motion and takes first word
// - Motion delay end negates accelerating
// - Phase mode data write at tape start writes ID burst
// - Preamble: forty zeros then one ones
// - Split words, request next word each time
// - Each character increments count, adds parity
// - Phase overflow: end of block, then postamble
// - NRZI characters update cyclic check generator
// - NRZI overflow: end of block, cyclic, longitudinal
// - First record density locks tape mode
// - Record end: delay, stop, clear go
// - Tape mark starts motion without waiting run
// - Phase tape mark: lines low, 80 pulses
// - NRZI tape mark, gap, longitudinal strobe
// - Tape mark read back: delay then stop
// - Space stops at tape mark
// - Delay counter runs on divided rate clock
`timescale 1ns/100ps
module tfw_write_seq
    import tfw_pkg::*;
#(
    parameter logic [7:0]  RATE_DIV     = 8'h04,
    parameter logic [11:0] MOTION_DELAY = 12'h010,
    parameter logic [7:0]  CHAR_EDGES   = 8'h04,
    parameter logic [7:0]  IDB_CHARS    = 8'h20
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // Host tape control and frame count loads
    input  wire logic        tc_write,
    input  wire logic [2:0]  tc_select,
    input  wire logic [2:0]  tc_density,
    input  wire logic        fc_load,
    input  wire logic [15:0] fc_value,
    // Host command, run and data word
    input  wire logic        cmd_write,
    input  wire logic [5:0]  cmd_func,
    input  wire logic        error_in,
    input  wire logic        run,
    input  wire logic [15:0] data_word,
    output logic             word_take,
    output logic             bus_occupied,
    output logic             end_of_block,
    output logic             go,
    output logic [15:0]      frame_count,
    output logic             pe_mode,
    // Read-back and space status
    input  wire logic        read_end_of_record,
    input  wire logic        read_tape_mark,
    input  wire logic        space_active,
    // Transport side
    input  wire logic        tape_start,
    input  wire logic        transport_ref_clock,
    input  wire logic        transport_write_clock,
    output logic [2:0]       transport_select,
    output logic [2:0]       density_select,
    output logic             forward_dir,
    output logic             write_enable,
    output logic             motion_start_pulse,
    output logic             accelerating,
    output logic             stop_motion,
    output logic [7:0]       write_line,
    output logic             write_parity,
    output logic             record_pulse,
    output logic             long_check_strobe
);
    localparam logic [7:0] TM_GAP_EDGES = 8'(TM_GAP_CHARS * CHAR_EDGES);

    tfw_state_t       state_ff, nxt_state;
    logic [2:0]       sel_ff, den_ff;
    logic [FC_W-1:0]  fc_ff, nxt_fc;
    logic [15:0]      word_ff, nxt_word;
    logic             half_ff, nxt_half;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic [8:0]       crc_ff, nxt_crc, lrc_ff, nxt_lrc;
    logic [7:0]       line_ff, nxt_line;
    logic             par_ff, nxt_par, rec_ff, nxt_rec;
    logic             lcs_ff, nxt_lcs, eob_ff, nxt_eob, stop_ff, nxt_stop;
    logic             msp_ff, nxt_msp, go_ff, nxt_go, wr_ff, nxt_wr;
    logic             tm_ff, nxt_tm, pe_ff, nxt_pe, bot_ff, nxt_bot;
    logic [7:0]       lock_ff, lmode_ff;
    logic             wc_s1, wc_s2, wc_s3, rc_s1, rc_s2, rc_s3;
    logic             take, dly_start, rate_tick, dly_done, lock_now;

    // Write clock and reference clock synchronisers and edges
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            {wc_s1, wc_s2, wc_s3} <= 3'h0;
            {rc_s1, rc_s2, rc_s3} <= 3'h0;
        end else begin
            {wc_s1, wc_s2, wc_s3} <= {transport_write_clock, wc_s1, wc_s2};
            {rc_s1, rc_s2, rc_s3} <= {transport_ref_clock, rc_s1, rc_s2};
        end
    end
    wire wclk_edge = wc_s2 & ~wc_s3;
    wire ref_edge  = rc_s2 & ~rc_s3;

    // Delay rate clock and motion delay counter
    tfw_rate_div #(.RATE_DIV(RATE_DIV)) u_div (
        .clk       (clk),
        .reset_n   (reset_n),
        .ref_edge  (ref_edge),
        .rate_tick (rate_tick)
    );
    tfw_motion_delay #(.MOTION_DELAY(MOTION_DELAY)) u_dly (
        .clk       (clk),
        .reset_n   (reset_n),
        .start     (dly_start),
        .rate_tick (rate_tick),
        .done      (dly_done)
    );

    // Command decode, character selection and mode choice
    wire        is_wfwd   = cmd_write && (cmd_func == FN_WRITE_FWD);
    wire        is_wtm    = cmd_write && (cmd_func == FN_WRITE_TM);
    wire [7:0]  data_char = half_ff ? word_ff[15:8] : word_ff[7:0];
    wire        data_par  = ~^data_char;
    wire [15:0] fc_inc    = fc_ff + FC_ONE;
    wire [8:0]  crc_mix   = crc_ff ^ {data_par, data_char};
    wire [8:0]  crc_step  = {crc_mix[7:0], 1'b0} ^ (crc_mix[8] ? CRC_POLY : 9'h000);
    wire        den_pe    = (den_ff == DEN_PE);
    wire        pe_pick   = (tape_start || !lock_ff[sel_ff]) ? den_pe : lmode_ff[sel_ff];

    // Sequencer next state
    always_comb begin
        nxt_state = state_ff;
        nxt_fc    = fc_load ? fc_value : fc_ff;
        nxt_word  = word_ff;
        nxt_half  = half_ff;
        nxt_cnt   = cnt_ff;
        nxt_crc   = crc_ff;
        nxt_lrc   = lrc_ff;
        nxt_line  = line_ff;
        nxt_par   = par_ff;
        nxt_rec   = 1'b0;
        nxt_lcs   = 1'b0;
        nxt_eob   = 1'b0;
        nxt_stop  = 1'b0;
        nxt_msp   = 1'b0;
        nxt_go    = go_ff;
        nxt_wr    = wr_ff;
        nxt_tm    = tm_ff;
        nxt_pe    = pe_ff;
        nxt_bot   = bot_ff;
        take      = 1'b0;
        dly_start = 1'b0;
        lock_now  = 1'b0;
        case (state_ff)
            S_IDLE: begin
                nxt_wr = 1'b0;
                if ((is_wfwd || is_wtm) && !error_in) begin
                    nxt_wr    = 1'b1;
                    nxt_go    = 1'b1;
                    nxt_tm    = is_wtm;
                    nxt_pe    = pe_pick;
                    nxt_bot   = tape_start;
                    nxt_crc   = 9'h000;
                    nxt_lrc   = 9'h000;
                    nxt_cnt   = 8'h00;
                    lock_now  = 1'b1;
                    nxt_state = S_RUNW;
                    if (is_wtm) begin
                        nxt_msp   = 1'b1;
                        dly_start = 1'b1;
                        nxt_state = S_ACCEL;
                    end
                end else if (space_active && read_tape_mark) begin
                    dly_start = 1'b1;
                    nxt_state = S_STOPD;
                end
            end
            S_RUNW: begin
                if (run) begin
                    nxt_msp   = 1'b1;
                    take      = 1'b1;
                    nxt_word  = data_word;
                    nxt_half  = 1'b0;
                    dly_start = 1'b1;
                    nxt_state = S_ACCEL;
                end
            end
            S_ACCEL: begin
                if (dly_done) begin
                    if (tm_ff) begin
                        nxt_state = pe_ff ? S_TMPE : S_TMNR;
                    end else if (pe_ff) begin
                        nxt_state = bot_ff ? S_IDB : S_PRE;
                    end else begin
                        nxt_state = S_DATA;
                    end
                end
            end
            S_IDB: begin
                if (wclk_edge) begin
                    nxt_line = CHAR_ONES;
                    nxt_par  = 1'b1;
                    nxt_rec  = 1'b1;
                    nxt_cnt  = cnt_ff + CNT_ONE;
                    if (cnt_ff == IDB_CHARS - CNT_ONE) begin
                        nxt_cnt   = 8'h00;
                        nxt_state = S_PRE;
                    end
                end
            end
            S_PRE: begin
                if (wclk_edge) begin
                    nxt_rec  = 1'b1;
                    nxt_cnt  = cnt_ff + CNT_ONE;
                    nxt_line = CHAR_ZERO;
                    nxt_par  = 1'b0;
                    if (cnt_ff == PRE_ZEROS) begin
                        nxt_line  = CHAR_ONES;
                        nxt_par   = 1'b1;
                        nxt_cnt   = 8'h00;
                        nxt_state = S_DATA;
                    end
                end
            end
            S_DATA: begin
                if (wclk_edge) begin
                    nxt_line = data_char;
                    nxt_par  = data_par;
                    nxt_rec  = 1'b1;
                    nxt_fc   = fc_inc;
                    nxt_half = !half_ff;
                    nxt_crc  = crc_step;
                    nxt_lrc  = lrc_ff ^ {data_par, data_char};
                    if (half_ff && fc_inc != 16'h0000) begin
                        take     = 1'b1;
                        nxt_word = data_word;
                    end
                    if (fc_inc == 16'h0000) begin
                        nxt_eob   = 1'b1;
                        nxt_state = pe_ff ? S_POST : S_CRC;
                    end
                end
            end
            S_POST: begin
                if (wclk_edge) begin
                    nxt_rec  = 1'b1;
                    nxt_line = (cnt_ff == 8'h00) ? CHAR_ONES : CHAR_ZERO;
                    nxt_par  = (cnt_ff == 8'h00);
                    nxt_cnt  = cnt_ff + CNT_ONE;
                    if (cnt_ff == PRE_ZEROS) begin
                        nxt_state = S_READ;
                    end
                end
            end
            S_CRC: begin
                if (wclk_edge) begin
                    nxt_line  = crc_ff[7:0];
                    nxt_par   = crc_ff[8];
                    nxt_rec   = 1'b1;
                    nxt_lrc   = lrc_ff ^ crc_ff;
                    nxt_state = S_LRC;
                end
            end
            S_LRC: begin
                if (wclk_edge) begin
                    nxt_line  = lrc_ff[7:0];
                    nxt_par   = lrc_ff[8];
                    nxt_lcs   = 1'b1;
                    nxt_state = S_READ;
                end
            end
            S_TMPE: begin
                if (wclk_edge) begin
                    nxt_line = CHAR_ZERO & ~TM_PE_LOW;
                    nxt_par  = 1'b0;
                    nxt_rec  = 1'b1;
                    nxt_cnt  = cnt_ff + CNT_ONE;
                    if (cnt_ff == TM_PE_PULSES - CNT_ONE) begin
                        nxt_state = S_READ;
                    end
                end
            end
            S_TMNR: begin
                if (wclk_edge) begin
                    nxt_line  = TM_NRZI_CHAR;
                    nxt_par   = ~^TM_NRZI_CHAR;
                    nxt_rec   = 1'b1;
                    nxt_cnt   = 8'h00;
                    nxt_state = S_TMGAP;
                end
            end
            S_TMGAP: begin
                if (wclk_edge) begin
                    nxt_cnt = cnt_ff + CNT_ONE;
                    if (cnt_ff == TM_GAP_EDGES - CNT_ONE) begin
                        nxt_lcs   = 1'b1;
                        nxt_state = S_READ;
                    end
                end
            end
            S_READ: begin
                if ((!tm_ff && read_end_of_record) || (tm_ff && read_tape_mark)) begin
                    dly_start = 1'b1;
                    nxt_state = S_STOPD;
                end
            end
            S_STOPD: begin
                if (dly_done) begin
                    nxt_stop  = 1'b1;
                    nxt_go    = 1'b0;
                    nxt_wr    = 1'b0;
                    nxt_state = S_IDLE;
                end
            end
            default: begin
                nxt_state = S_IDLE;
            end
        endcase
    end

    // Tape control fields and per-transport mode lock
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sel_ff   <= 3'h0;
            den_ff   <= 3'h0;
            lock_ff  <= 8'h00;
            lmode_ff <= 8'h00;
        end else begin
            if (tc_write) begin
                sel_ff <= tc_select;
                den_ff <= tc_density;
            end
            if (lock_now) begin
                lock_ff[sel_ff]  <= 1'b1;
                lmode_ff[sel_ff] <= pe_pick;
            end
        end
    end

    // Sequencer registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= S_IDLE;
            {fc_ff, word_ff, half_ff, cnt_ff} <= '0;
            {crc_ff, lrc_ff, line_ff, par_ff} <= '0;
            {rec_ff, lcs_ff, eob_ff, stop_ff, msp_ff} <= 5'h00;
            {go_ff, wr_ff, tm_ff, pe_ff, bot_ff} <= 5'h00;
        end else begin
            state_ff <= nxt_state;
            {fc_ff, word_ff, half_ff, cnt_ff} <= {nxt_fc, nxt_word, nxt_half, nxt_cnt};
            {crc_ff, lrc_ff, line_ff, par_ff} <= {nxt_crc, nxt_lrc, nxt_line, nxt_par};
            {rec_ff, lcs_ff, eob_ff, stop_ff, msp_ff} <=
                {nxt_rec, nxt_lcs, nxt_eob, nxt_stop, nxt_msp};
            {go_ff, wr_ff, tm_ff, pe_ff, bot_ff} <= {nxt_go, nxt_wr, nxt_tm, nxt_pe, nxt_bot};
        end
    end

    // Outputs
    assign word_take          = take;
    assign bus_occupied       = go_ff && !tm_ff;
    assign end_of_block       = eob_ff;
    assign go                 = go_ff;
    assign frame_count        = fc_ff;
    assign pe_mode            = pe_ff;
    assign transport_select   = sel_ff;
    assign density_select     = den_ff;
    assign forward_dir        = wr_ff;
    assign write_enable       = wr_ff;
    assign motion_start_pulse = msp_ff;
    assign accelerating       = (state_ff == S_ACCEL);
    assign stop_motion        = stop_ff;
    assign write_line         = line_ff;
    assign write_parity       = par_ff;
    assign record_pulse       = rec_ff;
    assign long_check_strobe  = lcs_ff;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    property p_decode;
        (state_ff == S_IDLE) && is_wfwd && !error_in |=> forward_dir && write_enable;
    endproperty
    a_decode: assert property (p_decode) else $error("write lines not raised");
    property p_err;
        (state_ff == S_IDLE) && cmd_write && error_in |=> !bus_occupied;
    endproperty
    a_err: assert property (p_err) else $error("occupied despite error");
    property p_run;
        (state_ff == S_RUNW) && run |-> word_take ##1 motion_start_pulse ##1 !motion_start_pulse;
    endproperty
    a_run: assert property (p_run) else $error("run did not start motion");
    property p_accel;
        (state_ff == S_ACCEL) && dly_done |=> !accelerating;
    endproperty
    a_accel: assert property (p_accel) else $error("accelerating held after delay");
    property p_pre;
        (state_ff == S_PRE) && wclk_edge && cnt_ff == PRE_ZEROS |=> write_line == CHAR_ONES
            && state_ff == S_DATA;
    endproperty
    a_pre: assert property (p_pre) else $error("preamble end wrong");
    property p_fc;
        (state_ff == S_DATA) && wclk_edge && !fc_load |=>
            frame_count == $past(frame_count) + FC_ONE && record_pulse;
    endproperty
    a_fc: assert property (p_fc) else $error("frame count not advanced");
    property p_eob;
        (state_ff == S_DATA) && wclk_edge && fc_ff == FC_LAST |=> end_of_block ##1 !end_of_block;
    endproperty
    a_eob: assert property (p_eob) else $error("end of block missing");
    property p_tmpe;
        (state_ff == S_TMPE) && wclk_edge |=> (write_line & TM_PE_LOW) == 8'h00 && record_pulse;
    endproperty
    a_tmpe: assert property (p_tmpe) else $error("tape mark lines wrong");
    property p_tmnr;
        (state_ff == S_TMNR) && wclk_edge |=> write_line == TM_NRZI_CHAR && record_pulse;
    endproperty
    a_tmnr: assert property (p_tmnr) else $error("nrzi tape mark wrong");
    property p_stop;
        (state_ff == S_STOPD) && dly_done |=> stop_motion && !go && !bus_occupied;
    endproperty
    a_stop: assert property (p_stop) else $error("stop not issued");
    c_data: cover property ((state_ff == S_DATA) ##[1:1000] end_of_block);
    c_tm:   cover property ((state_ff == S_TMGAP) ##[1:300] long_check_strobe);
    c_stop: cover property (stop_motion && tm_ff);
endmodule

// [dv/tfw_transport.sv]
// Behavioural tape transport: reference clock and write clock
`timescale 1ns/100ps
module tfw_transport (
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // Motion control from the formatter
    input  wire logic motion_start_pulse,
    input  wire logic accelerating,
    input  wire logic stop_motion,
    // Clocks back to the formatter
    output logic      transport_ref_clock,
    output logic      transport_write_clock
);
    logic moving_ff;
    logic armed_ff;
    // Free running reference clock while online
    initial begin
        transport_ref_clock = 1'b0;
        forever #50 transport_ref_clock = ~transport_ref_clock;
    end
    // Start on the motion pulse, write clock only once up to speed
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n || stop_motion) begin
            moving_ff <= 1'b0;
            armed_ff  <= 1'b0;
        end else begin
            if (motion_start_pulse) moving_ff <= 1'b1;
            if (moving_ff && accelerating) armed_ff <= 1'b1;
        end
    end
    // Write clock stands still outside motion
    initial begin
        transport_write_clock = 1'b0;
        forever #100 transport_write_clock = armed_ff && !accelerating && !transport_write_clock;
    end
endmodule

// [dv/tb_top.sv]
// Self-checking bench for the tape write sequencer
`timescale 1ns/100ps
module tb_top;
    import tfw_pkg::*;
    logic clk = 0, reset_n = 0, tc_write = 0, fc_load = 0, cmd_write = 0, error_in = 0, run = 0;
    logic [2:0] tc_select = 0, tc_density = 0;
    logic [15:0] fc_value = 0, data_word = 0, frame_count;
    logic [5:0] cmd_func = 0;
    logic read_end_of_record = 0, read_tape_mark = 0, space_active = 0, tape_start = 0;
    logic word_take, bus_occupied, end_of_block, go, pe_mode, transport_ref_clock;
    logic transport_write_clock, forward_dir, write_enable, motion_start_pulse, accelerating;
    logic stop_motion, write_parity, record_pulse, long_check_strobe;
    logic [2:0] transport_select, density_select;
    logic [7:0] write_line;
    int n_mismatch = 0, compares = 0, n_rp = 0, n_wt = 0;
    int q_wt[$], q_rp[$];
    tfw_write_seq #(.MOTION_DELAY(12'h002), .IDB_CHARS(8'h02)) tfw_write_seq_inst (.clk, .reset_n,
        .tc_write, .tc_select, .tc_density, .fc_load, .fc_value, .cmd_write, .cmd_func, .error_in,
        .run, .data_word, .word_take, .bus_occupied, .end_of_block, .go, .frame_count, .pe_mode,
        .read_end_of_record, .read_tape_mark, .space_active, .tape_start, .transport_ref_clock,
        .transport_write_clock, .transport_select, .density_select, .forward_dir, .write_enable,
        .motion_start_pulse, .accelerating, .stop_motion, .write_line, .write_parity,
        .record_pulse, .long_check_strobe);
    tfw_transport tfw_transport_inst (.clk, .reset_n, .motion_start_pulse, .accelerating,
        .stop_motion, .transport_ref_clock, .transport_write_clock);
    initial begin
        forever #10 clk = ~clk;
    end
    task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR at %0t: %s", $time, m);
        end
    endtask
    task automatic final_report();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Bounded wait on a level sampled mid-cycle
    task automatic wait_hi(ref logic s, input string m);
        int k;
        for (k = 0; k < 20000 && s !== 1'b1; k++) @(negedge clk);
        chk(16'(s), 16'h0001, m);
    endtask
    // Results: word count at end of block, pulse count at stop
    always @(posedge clk) begin
        if (record_pulse) n_rp++;
        if (word_take) begin
            n_wt++;
            data_word <= 16'($urandom);
        end
        if (end_of_block && q_wt.size() > 0) chk(16'(n_wt), 16'(q_wt.pop_front()), "words");
        if (stop_motion && q_rp.size() > 0) begin
            if (q_rp[0] >= 0) chk(16'(n_rp), 16'(q_rp[0]), "record pulses");
            void'(q_rp.pop_front());
        end
    end
    task automatic cmd(input logic [2:0] den, input logic ts, input logic [5:0] fn,
                       input int n, input logic pe, input logic err);
        @(posedge clk);
        tape_start <= ts;
        tc_density <= den;
        tc_select <= ts ? 3'($urandom) : tc_select;
        tc_write <= 1;
        error_in <= err;
        @(posedge clk);
        tc_write <= 0;
        fc_load <= 1;
        fc_value <= 16'(-n);
        @(posedge clk);
        fc_load <= 0;
        cmd_write <= 1;
        cmd_func <= fn;
        n_rp = 0;
        n_wt = 0;
        @(posedge clk);
        cmd_write <= 0;
        error_in <= 0;
        @(negedge clk);
        chk({10'h0, transport_select, density_select}, {10'h0, tc_select, tc_density}, "sel");
        chk(16'(go), 16'(!err), "go");
        chk(16'(forward_dir & write_enable), 16'(!err), "fwd");
        chk(16'(bus_occupied), 16'(!err && fn == FN_WRITE_FWD), "occ");
        if (err) return;
        chk(16'(pe_mode), 16'(pe), "mode");
        if (fn == FN_WRITE_FWD) begin
            q_wt.push_back((n + 1) / 2);
            q_rp.push_back(pe ? 82 + 2 * int'(ts) + n : n + 1);
            @(posedge clk);
            run <= 1;
            @(negedge clk);
            chk(16'(word_take), 16'h0001, "take");
            @(posedge clk);
            run <= 0;
            @(negedge clk);
            chk(16'(motion_start_pulse), 16'h0001, "start");
            wait_hi(end_of_block, "eob");
            // Postamble edges, then let the last one pass the synchroniser
            if (pe) begin
                repeat (41) @(posedge transport_write_clock);
                repeat (3) @(posedge clk);
            end else wait_hi(long_check_strobe, "lrc");
            @(posedge clk);
            read_end_of_record <= 1;
        end else begin
            chk(16'(motion_start_pulse), 16'h0001, "tm start");
            q_rp.push_back(pe ? 80 : 1);
            if (pe) for (int k = 0; k < 40000 && n_rp < 80; k++) @(negedge clk);
            else wait_hi(long_check_strobe, "tm lrc");
            @(posedge clk);
            read_tape_mark <= 1;
        end
        @(posedge clk);
        read_end_of_record <= 0;
        read_tape_mark <= 0;
        wait_hi(stop_motion, "stop");
        @(negedge clk);
        chk({15'h0, go}, 16'h0000, "go clear");
        if (fn == FN_WRITE_TM || pe)
            chk(16'(write_line), 16'(pe ? CHAR_ZERO : TM_NRZI_CHAR), "line");
        if (fn == FN_WRITE_FWD) chk(frame_count, 16'h0000, "count");
    endtask
    initial begin
        #1500000;
        n_mismatch++;
        final_report();
    end
    initial begin
        void'($urandom(32'h5bf3));
        repeat (4) @(posedge clk);
        reset_n <= 1;
        cmd(DEN_PE, 1, FN_WRITE_FWD, 0, 1, 1);
        cmd(DEN_PE, 1, FN_WRITE_FWD, 3 + $urandom % 4, 1, 0);
        cmd(3'h3, 0, FN_WRITE_TM, 0, 1, 0);
        cmd(3'h3, 1, FN_WRITE_FWD, 3 + $urandom % 4, 0, 0);
        cmd(3'h3, 0, FN_WRITE_TM, 0, 0, 0);
        @(posedge clk);
        space_active <= 1;
        read_tape_mark <= 1;
        @(posedge clk);
        read_tape_mark <= 0;
        wait_hi(stop_motion, "space stop");
        @(posedge clk) space_active <= 0;
        final_report();
    end
endmodule
